// file: rtl/perf_event_consts.svh
`ifndef PERF_EVENT_CONSTS_SVH
`define PERF_EVENT_CONSTS_SVH

// event codes
`define EV_INTER_CORE_SNOOP   8'h78
`define EV_CLEAN_HIT_RESP     8'h7a
`define EV_MOD_HIT_RESP       8'h7b
`define EV_BUSQ_IDLE          8'h7d
`define EV_SNOOP_STALL        8'h7e
`define EV_IO_WAIT            8'h7f
`define EV_FETCH_COUNT        8'h80
`define EV_FETCH_MISS         8'h81
`define EV_ITB_MISS           8'h82

// unit masks
`define UM_NONE               8'h00
`define UM_SMALL_MISS         8'h02
`define UM_LARGE_MISS         8'h10
`define UM_CORE_FIELD_MSB     7
`define UM_CORE_FIELD_LSB     6
`define UM_CORE_BOTH          2'h3

// register offsets
`define REG_EVSEL             4'h0
`define REG_COUNT             4'h1
`define REG_STATUS            4'h2
`define REG_DEFER_CNT         4'h3

// field positions in the event-select register
`define EVSEL_CODE_LSB        0
`define EVSEL_MASK_LSB        8
`define EVSEL_EN_BIT          16

// reset values and counts
`define EVSEL_RESET           32'h0000_0000
`define SNOOP_STALL_WEIGHT    2
`define SNOOP_RESP_LIMIT      3

`endif

// file: rtl/perf_event_pkg.sv
package perf_event_pkg;

  // cache line state as held by this core
  typedef enum logic [1:0] {
    line_inv,
    line_shr,
    line_exc,
    line_mod
  } line_state_t;

  // snoop request from the other core
  typedef struct packed {
    logic        valid;
    logic        rfo;     // read for ownership, otherwise plain read
    logic [7:0]  index;
  } snoop_req_t;

  // condition inputs from pipeline, caches and bus
  typedef struct packed {
    logic clean_hit_drv;
    logic mod_hit_drv;
    logic bus_queue_idle_cycles_this_core_only_modifier;
    logic bus_queue_idle_cycles_other;
    logic halted_this_core_only_modifier;
    logic halted_other;
    logic stall_asserted;
    logic io_wait_this_core_only_modifier;
    logic io_wait_other;
    logic fetch;
    logic fetch_miss;
    logic itb_small_miss;
    logic itb_large_miss;
  } event_in_t;

  // register bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } reg_req_t;

endpackage : perf_event_pkg

// file: rtl/perf_event_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_consts.svh"

module perf_event_select #(
  parameter int CNT_W  = 32,
  parameter int LINES  = 256
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire perf_event_pkg::reg_req_t  reg_req,
  output logic [31:0]                    reg_rdata,
  input  wire perf_event_pkg::event_in_t ev_in,
  input  wire perf_event_pkg::snoop_req_t snoop_req,
  input  wire logic                      line_fill,
  input  wire logic [7:0]                line_fill_index,
  input  wire logic                      line_fill_excl,
  input  wire logic                      store_req,
  input  wire logic [7:0]                store_index,
  input  wire logic                      snoop_late,
  output logic                           store_stall,
  output logic [1:0]                     snoop_line_state,
  output logic                           snoop_stall_out,
  output logic                           bus_start_block
);
  import perf_event_pkg::*;

  // control and state registers
  logic [31:0]       evsel_r;
  logic [CNT_W-1:0]  count_r;
  logic [CNT_W-1:0]  count_nxt;
  logic [31:0]       rdata_r;
  logic [31:0]       rdata_nxt;
  logic [15:0]       defer_cnt_r;
  line_state_t       line_r [LINES];
  logic [LINES-1:0]  defer_r;
  logic [1:0]        late_cnt_r;
  logic              stall_r;
  logic              store_stall_r;
  logic [1:0]        snoop_state_r;
  logic              fetch_miss_d_r;

  // event select fields
  wire logic [7:0] ev_code  = evsel_r[`EVSEL_CODE_LSB +: 8];
  wire logic [7:0] ev_mask  = evsel_r[`EVSEL_MASK_LSB +: 8];
  wire logic       ev_en    = evsel_r[`EVSEL_EN_BIT];
  wire logic       both_sel = (ev_mask[`UM_CORE_FIELD_MSB:`UM_CORE_FIELD_LSB] == `UM_CORE_BOTH);

  // compares a code and exact mask against the programmed selection
  function automatic logic sel_is(input logic [7:0] code, input logic [7:0] mask,
                                  input logic [7:0] c, input logic [7:0] m);
    sel_is = (code == c) && (mask == m);
  endfunction : sel_is

  // snoop decode against the line tag state
  wire line_state_t snp_state = line_r[snoop_req.index];
  wire logic snp_hit    = snoop_req.valid && (snp_state != line_inv);
  wire logic snp_mod    = snp_hit && (snp_state == line_mod);
  wire logic snp_dngr   = snp_hit && !snoop_req.rfo && (snp_state == line_exc);
  wire logic snp_inval  = snp_hit && snoop_req.rfo &&
                          ((snp_state == line_exc) || (snp_state == line_shr));
  wire logic snp_defer  = snp_mod;
  wire logic defer_go   = !snoop_req.valid && |defer_r;             // later opportunity

  // lowest pending deferred line
  function automatic logic [7:0] first_set(input logic [LINES-1:0] v);
    first_set = 8'h00;
    for (int i = LINES - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 8'(i);
      end
    end
  endfunction : first_set

  wire logic [7:0] defer_idx = first_set(defer_r);

  // event qualification
  wire logic fetch_miss_edge = ev_in.fetch_miss && !fetch_miss_d_r;
  wire logic busq_idle_this_core_only_modifier  = ev_in.bus_queue_idle_cycles_this_core_only_modifier ||
                               (ev_in.halted_this_core_only_modifier && !ev_in.halted_other);
  wire logic busq_idle_other = ev_in.bus_queue_idle_cycles_other ||
                               (ev_in.halted_other && !ev_in.halted_this_core_only_modifier);
  wire logic stall_rise      = ev_in.stall_asserted && !stall_r;

  wire logic hit_snoop  = (ev_code == `EV_INTER_CORE_SNOOP) && snoop_req.valid;
  wire logic hit_clean  = (ev_code == `EV_CLEAN_HIT_RESP) && ev_in.clean_hit_drv;
  wire logic hit_mod    = (ev_code == `EV_MOD_HIT_RESP) && ev_in.mod_hit_drv;
  wire logic hit_idle   = (ev_code == `EV_BUSQ_IDLE) &&
                          (busq_idle_this_core_only_modifier || (both_sel && busq_idle_other));
  wire logic hit_stall  = (ev_code == `EV_SNOOP_STALL) && stall_rise;
  wire logic hit_io     = (ev_code == `EV_IO_WAIT) &&
                          (ev_in.io_wait_this_core_only_modifier || (both_sel && ev_in.io_wait_other));
  wire logic hit_fetch  = sel_is(ev_code, ev_mask, `EV_FETCH_COUNT, `UM_NONE) &&
                          ev_in.fetch;
  wire logic hit_fmiss  = sel_is(ev_code, ev_mask, `EV_FETCH_MISS, `UM_NONE) &&
                          fetch_miss_edge;
  wire logic hit_small  = sel_is(ev_code, ev_mask, `EV_ITB_MISS, `UM_SMALL_MISS) &&
                          ev_in.itb_small_miss;
  wire logic hit_large  = sel_is(ev_code, ev_mask, `EV_ITB_MISS, `UM_LARGE_MISS) &&
                          ev_in.itb_large_miss;

  // one increment per cycle at most; unmatched selections add nothing
  wire logic ev_hit = ev_en && (hit_snoop || hit_clean || hit_mod || hit_idle ||
                      hit_stall || hit_io || hit_fetch || hit_fmiss ||
                      hit_small || hit_large);

  // counter next value
  always_comb begin
    count_nxt = count_r;
    if (reg_req.wr && (reg_req.addr == `REG_COUNT)) begin
      count_nxt = reg_req.wdata[CNT_W-1:0];
    end else if (ev_hit) begin
      count_nxt = count_r + CNT_W'(1);
    end
  end

  // read mux
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_req.rd) begin
      case (reg_req.addr)
        `REG_EVSEL:     rdata_nxt = evsel_r;
        `REG_COUNT:     rdata_nxt = 32'(count_r);
        `REG_STATUS:    rdata_nxt = {28'h0000000, stall_r, store_stall_r,
                                     (|defer_r), fetch_miss_d_r};
        `REG_DEFER_CNT: rdata_nxt = {16'h0000, defer_cnt_r};
        default:        rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // register file and counter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      evsel_r <= `EVSEL_RESET;
      count_r <= '0;
      rdata_r <= 32'h0000_0000;
    end else begin
      if (reg_req.wr && (reg_req.addr == `REG_EVSEL)) begin
        evsel_r <= reg_req.wdata;
      end
      count_r <= count_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // edge trackers for once-per-event counting
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fetch_miss_d_r <= 1'b0;
      stall_r        <= 1'b0;
    end else begin
      fetch_miss_d_r <= ev_in.fetch_miss;
      stall_r        <= ev_in.stall_asserted;
    end
  end

  // line state tracking under inter-core snoops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < LINES; i++) begin
        line_r[i] <= line_inv;
      end
      defer_r     <= '0;
      defer_cnt_r <= 16'h0000;
    end else begin
      if (line_fill) begin
        line_r[line_fill_index] <= line_fill_excl ? line_exc : line_shr;
      end
      if (store_req && !snoop_req.valid && (line_r[store_index] != line_inv)) begin
        line_r[store_index] <= line_mod;
      end
      if (snp_dngr) begin
        line_r[snoop_req.index] <= line_shr;
      end else if (snp_inval) begin
        line_r[snoop_req.index] <= line_inv;
      end else if (snp_defer) begin
        defer_r[snoop_req.index] <= 1'b1;
        defer_cnt_r              <= defer_cnt_r + 16'h0001;
      end
      if (defer_go) begin
        line_r[defer_idx]  <= line_inv;
        defer_r[defer_idx] <= 1'b0;
      end
    end
  end

  // snoop-stall drive when a response is late
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      late_cnt_r      <= 2'h0;
      snoop_stall_out <= 1'b0;
    end else begin
      if (snoop_late && (late_cnt_r != 2'(`SNOOP_RESP_LIMIT))) begin
        late_cnt_r <= late_cnt_r + 2'h1;
      end else if (!snoop_late) begin
        late_cnt_r <= 2'h0;
      end
      snoop_stall_out <= snoop_late &&
                         (late_cnt_r >= 2'(`SNOOP_RESP_LIMIT - 1));
    end
  end

  // store port arbitration and registered outputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      store_stall_r   <= 1'b0;
      snoop_state_r   <= 2'h0;
      bus_start_block <= 1'b0;
    end else begin
      store_stall_r   <= store_req && snoop_req.valid;
      snoop_state_r   <= snoop_req.valid ? snp_state : 2'h0;
      bus_start_block <= ev_in.stall_asserted;
    end
  end

  assign reg_rdata        = rdata_r;
  assign store_stall      = store_stall_r;
  assign snoop_line_state = snoop_state_r;

endmodule : perf_event_select
`default_nettype wire

// file: tb/perf_event_select_sva.sv
`timescale 1ns/1ps
`default_nettype none
module perf_event_select_sva (
  input wire logic                       core_clk,
  input wire logic                       rst,
  input wire perf_event_pkg::event_in_t  ev_in,
  input wire perf_event_pkg::snoop_req_t snoop_req,
  input wire logic                       line_fill,
  input wire logic                       store_req,
  input wire logic                       snoop_late,
  input wire logic                       store_stall,
  input wire logic [1:0]                 snoop_line_state,
  input wire logic                       snoop_stall_out,
  input wire logic                       bus_start_block
);
  import perf_event_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // a snoop with no fill or store beside it
  sequence quiet_s;
    snoop_req.valid && !line_fill && !store_req;
  endsequence
  // two snoops in a row to one line, the second a plain read
  sequence pair_s(bit r1);
    (quiet_s and snoop_req.rfo == r1) ##1
    (quiet_s and !snoop_req.rfo && snoop_req.index == $past(snoop_req.index));
  endsequence
  snoop_idle_a: assert property (!snoop_req.valid |=> snoop_line_state == 2'h0)
    else $error("line state shown without a snoop");
  read_share_a: assert property (pair_s(0) ##0 snoop_line_state == 2'h2 |=> snoop_line_state == 2'h1)
    else $error("exclusive line not shared after read snoop");
  own_inval_a: assert property (pair_s(1) ##0 snoop_line_state inside {2'h1, 2'h2}
    |=> snoop_line_state == 2'h0)
    else $error("line not invalid after ownership snoop");
  mod_defer_a: assert property (pair_s(0) ##0 snoop_line_state == 2'h3 |=> snoop_line_state == 2'h3)
    else $error("modified line changed at once");
  store_clash_a: assert property (store_req && snoop_req.valid |=> store_stall)
    else $error("store not stalled by snoop");
  block_follow_a: assert property (ev_in.stall_asserted |=> bus_start_block)
    else $error("bus start not blocked during stall");
  late_stall_a: assert property (snoop_late [*4] |=> snoop_stall_out)
    else $error("late snoop answer without stall");
  late_clear_a: assert property (!snoop_late |=> !snoop_stall_out)
    else $error("stall held with snoop answered");
endmodule : perf_event_select_sva
bind perf_event_select perf_event_select_sva perf_event_select_sva_i (.core_clk(core_clk),
  .rst(rst), .ev_in(ev_in), .snoop_req(snoop_req), .line_fill(line_fill),
  .store_req(store_req), .snoop_late(snoop_late), .store_stall(store_stall),
  .snoop_line_state(snoop_line_state), .snoop_stall_out(snoop_stall_out),
  .bus_start_block(bus_start_block));
`default_nettype wire

// file: tb/perf_event_partner.sv
`timescale 1ns/1ps
`default_nettype none
module perf_event_partner (
  input wire logic                       core_clk,
  input wire logic                       rst,
  input wire logic                       go,
  input wire logic                       go_rfo,
  input wire logic [7:0]                 go_idx,
  input wire logic                       block,
  output var perf_event_pkg::snoop_req_t snp
);
  import perf_event_pkg::*;
  // other core: one-cycle snoop per request, idle lines toggle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) snp <= '0;
    else if (go && !block) snp <= '{valid: 1'b1, rfo: go_rfo, index: go_idx};
    else snp <= '{valid: 1'b0, rfo: ~snp.rfo, index: ~snp.index};
  end
endmodule : perf_event_partner
`default_nettype wire

// file: tb/perf_event_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_consts.svh"
module perf_event_select_tb;
  import perf_event_pkg::*;
  logic core_clk, rst, line_fill, line_fill_excl, store_req, snoop_late, go, go_rfo;
  logic store_stall, snoop_stall_out, bus_start_block;
  logic [7:0] line_fill_index, store_index, go_idx;
  logic [1:0] snoop_line_state;
  logic [31:0] reg_rdata, exp_cnt;
  reg_req_t reg_req;
  event_in_t ev_in, prev_ev;
  snoop_req_t snoop_req;
  integer seed = 32'he734;
  int err_total, checks, cyc;
  logic [15:0] sel_tab [15] = '{16'h0078, 16'h007a, 16'h007b, 16'h007d, 16'hc07d, 16'h007e,
    16'h007f, 16'hc07f, 16'h0080, 16'h0081, 16'h0282, 16'h1082, 16'h4082, 16'h0055, 16'h0180};
  perf_event_select perf_event_select_i (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .ev_in(ev_in), .snoop_req(snoop_req), .line_fill(line_fill),
    .line_fill_index(line_fill_index), .line_fill_excl(line_fill_excl), .store_req(store_req),
    .store_index(store_index), .snoop_late(snoop_late), .store_stall(store_stall),
    .snoop_line_state(snoop_line_state), .snoop_stall_out(snoop_stall_out),
    .bus_start_block(bus_start_block));
  perf_event_partner perf_event_partner_i (.core_clk(core_clk), .rst(rst), .go(go),
    .go_rfo(go_rfo), .go_idx(go_idx), .block(bus_start_block), .snp(snoop_req));
  // expected increment for one sampled cycle
  function automatic logic inc(input logic [15:0] s, input event_in_t e, p, input logic sv);
    logic [7:0] m;
    logic       b;
    m = s[15:8];
    b = (m[7:6] == 2'h3);
    case (s[7:0])
      8'h78: return sv;
      8'h7a: return e.clean_hit_drv;
      8'h7b: return e.mod_hit_drv;
      8'h7d: return e.bus_queue_idle_cycles_this_core_only_modifier | (e.halted_this_core_only_modifier & !e.halted_other)
               | (b & (e.bus_queue_idle_cycles_other | (e.halted_other & !e.halted_this_core_only_modifier)));
      8'h7e: return e.stall_asserted & !p.stall_asserted;
      8'h7f: return e.io_wait_this_core_only_modifier | (b & e.io_wait_other);
      8'h80: return (m == 8'h00) & e.fetch;
      8'h81: return (m == 8'h00) & e.fetch_miss & !p.fetch_miss;
      8'h82: return (m == 8'h02) ? e.itb_small_miss : (m == 8'h10) & e.itb_large_miss;
      default: return 1'b0;
    endcase
  endfunction : inc
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk) reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk) reg_req <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk) reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge core_clk) reg_req <= '0;
    #1 check(reg_rdata, e);
  endtask : rd
  // fill (f=1) or store (f=0) one line
  task automatic put(input logic f, input logic [7:0] i, input logic x);
    @(posedge core_clk);
    line_fill <= f; line_fill_index <= i; line_fill_excl <= x;
    store_req <= !f; store_index <= i;
    @(posedge core_clk) begin line_fill <= 1'b0; store_req <= 1'b0; end
  endtask : put
  task automatic snp(input logic r, input logic [7:0] i, input logic [1:0] e);
    @(posedge core_clk) begin go <= 1'b1; go_rfo <= r; go_idx <= i; end
    @(posedge core_clk) go <= 1'b0;
    @(posedge core_clk);
    #1 check(32'(snoop_line_state), 32'(e));
  endtask : snp
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin err_total++; complete_run(); end
  end
  initial begin
    rst = 1'b1; reg_req = '0; ev_in = '0; line_fill = 1'b0; line_fill_index = 8'h00;
    line_fill_excl = 1'b0; store_req = 1'b0; store_index = 8'h00; snoop_late = 1'b0;
    go = 1'b0; go_rfo = 1'b0; go_idx = 8'h00;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rd(`REG_EVSEL, 32'h0);
    rd(`REG_COUNT, 32'h0);
    wr(4'hf, 32'hffff_ffff);
    rd(4'hf, 32'h0);
    put(1'b1, 8'h05, 1'b1);
    snp(1'b0, 8'h05, 2'h2);
    snp(1'b0, 8'h05, 2'h1);
    snp(1'b1, 8'h05, 2'h1);
    snp(1'b0, 8'h05, 2'h0);
    put(1'b1, 8'h06, 1'b0);
    snp(1'b1, 8'h06, 2'h1);
    snp(1'b0, 8'h06, 2'h0);
    put(1'b1, 8'h07, 1'b1);
    put(1'b0, 8'h07, 1'b0);
    snp(1'b0, 8'h07, 2'h3);
    snp(1'b0, 8'h07, 2'h0);
    rd(`REG_DEFER_CNT, 32'h1);
    rd(`REG_STATUS, 32'h0);
    @(posedge core_clk) snoop_late <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1 check(32'(snoop_stall_out), 32'h1);
    @(posedge core_clk) snoop_late <= 1'b0;
    @(posedge core_clk);
    #1 check(32'(snoop_stall_out), 32'h0);
    // every selection under random conditions, snoops and stores
    foreach (sel_tab[i]) begin
      wr(`REG_EVSEL, {15'h0, 1'b1, sel_tab[i]});
      wr(`REG_COUNT, 32'h0);
      exp_cnt = 32'h0;
      prev_ev = '0;
      for (int k = 0; k < 44; k++) begin
        @(posedge core_clk);
        exp_cnt += 32'(inc(sel_tab[i], ev_in, prev_ev, snoop_req.valid));
        prev_ev = ev_in;
        ev_in <= (k < 40) ? event_in_t'(13'($random(seed))) : '0;
        go <= (k < 40) ? 1'($random(seed)) : 1'b0;
        go_rfo <= 1'($random(seed));
        go_idx <= 8'($random(seed)) & 8'h03;
        store_req <= (k < 40) ? 1'($random(seed)) : 1'b0;
        store_index <= 8'($random(seed)) & 8'h03;
        line_fill <= (k < 40) ? 1'($random(seed)) : 1'b0;
        line_fill_index <= 8'($random(seed)) & 8'h03;
        line_fill_excl <= 1'($random(seed));
      end
      rd(`REG_COUNT, exp_cnt);
    end
    complete_run();
  end
endmodule : perf_event_select_tb
`default_nettype wire
